// *** rtl/trim_config_regs.v ***
// trim_config_regs.v: trim and protection configuration bank, AHB-Lite slave
// assumes factory inputs are static on CLK_SYS while RESET is high
//
// Function
// - a trim register unlocks only after unlock writes 01, 10, 11; field reads 11
// - while locked, writes to writable fields other than unlock are ignored
// - once at 11, only writing 00 clears the unlock field and relocks
// - at 11, writing any other value has no effect; field keeps reading 11
// - reference trim loads from factory area if its flag set, else zero
// - core regulator trim loads from factory area if its flag set, else zero
// - io regulator trim bits 17:16 load from factory area if flagged, else zero
// - after reset software may overwrite loaded trims, subject to unlock
// - reference power-down bit 1 powers the reference down, 0 keeps it on
// - io regulator bit 23 set requests power-down, clear keeps it running
// - io regulator bit 22 set selects bypass, clear selects normal operation
// - protect enable reads 0 if factory location erased, 1 if matched
// - protect override reads 1 if factory location erased, 0 if matched
// - local read bit loads like enable; 1 permits local reads, 0 forbids
// - upper and lower seven-bit pages load; size is difference times 512 bytes, zero if lower is above upper
`include "trim_map.vh"

module trim_config_regs
(
  input wire CLK_SYS,
  input wire RESET,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg HREADYOUT,
  output reg HRESP,
  output reg [31:0] HRDATA,
  input wire FIA_REF_TRIM_ENABLE_FLAG,
  input wire [4:0] FIA_REF_TRIM_VALUE,
  input wire FIA_CORE_REG_TRIM_ENABLE_FLAG,
  input wire [5:0] FIA_CORE_REG_TRIM_VALUE,
  input wire FIA_IO_REG_TRIM_ENABLE_FLAG,
  input wire [1:0] FIA_IO_REG_TRIM_VALUE,
  input wire FIA_PROTECT_ENABLE_MATCH,
  input wire FIA_PROTECT_OVERRIDE_MATCH,
  input wire FIA_PROTECT_LOCAL_READ_MATCH,
  input wire [6:0] FIA_PROTECT_UPPER_PAGE,
  input wire [6:0] FIA_PROTECT_LOWER_PAGE,
  output reg REF_POWER_DOWN,
  output reg [4:0] REF_TRIM_VALUE,
  output reg [5:0] CORE_REG_TRIM_VALUE,
  output reg [1:0] IO_REG_TRIM_VALUE,
  output reg IO_REG_POWER_DOWN,
  output reg IO_REG_BYPASS,
  output reg PROTECT_ENABLE_STATUS,
  output reg PROTECT_OVERRIDE_STATUS,
  output reg PROTECT_LOCAL_READ_STATUS,
  output reg [6:0] PROTECT_UPPER_PAGE,
  output reg [6:0] PROTECT_LOWER_PAGE,
  output reg [15:0] PROTECT_SIZE_BYTES
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [7:0] idx_reg;
  reg ref_flag_reg;
  reg core_flag_reg;
  reg io_flag_reg;
  wire [7:0] haddr_idx;
  wire take;
  wire wr_ref;
  wire wr_core;
  wire wr_io;
  wire [2:0] unlock_wr;
  wire [5:0] unlock_wval;
  wire [5:0] unlock_field;
  wire [2:0] unlocked;
  reg [31:0] rd_word;

  // only single whole-word transfers are used, so hsize is not decoded
  assign haddr_idx = HADDR[9:2];
  assign take = HSEL & HTRANS[1] & HREADY;

  function hit;
    input [7:0] idx;
    input [7:0] want;
    begin
      hit = (idx == want);
    end
  endfunction

  assign wr_ref = wr_pend_reg & hit(idx_reg, `REF_TRIM_IDX);
  assign wr_core = wr_pend_reg & hit(idx_reg, `CORE_TRIM_IDX);
  assign wr_io = wr_pend_reg & hit(idx_reg, `IO_TRIM_IDX);

  // ----------------------------------------
  // address and data phase tracking
  // ----------------------------------------
  // reads take one wait state so that a read right after a write sees the new value
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
    end
    else
    begin
      HRESP <= 1'b0;
      if (rd_pend_reg)
      begin
        rd_pend_reg <= 1'b0;
        HREADYOUT <= 1'b1;
        HRDATA <= rd_word;
      end
      else
      begin
        wr_pend_reg <= take & HWRITE;
        rd_pend_reg <= take & ~HWRITE;
        HREADYOUT <= ~(take & ~HWRITE);
        if (take)
        begin
          idx_reg <= haddr_idx;
        end
      end
    end
  end

  // ----------------------------------------
  // unlock sequencers
  // ----------------------------------------
  assign unlock_wr = {wr_io, wr_core, wr_ref};
  assign unlock_wval = {HWDATA[`IO_UNLOCK_HI:`IO_UNLOCK_LO],
    HWDATA[`CORE_UNLOCK_HI:`CORE_UNLOCK_LO],
    HWDATA[`REF_UNLOCK_HI:`REF_UNLOCK_LO]};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : seq
      unlock_seq u_seq
      (
        .clk(CLK_SYS),
        .rst(RESET),
        .wr_en(unlock_wr[g]),
        .wr_val(unlock_wval[2*g+1:2*g]),
        .field(unlock_field[2*g+1:2*g]),
        .unlocked(unlocked[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // trim fields
  // ----------------------------------------
  // factory values are taken while RESET is held; reset is synchronous,
  // so the load is an ordinary clocked capture
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      REF_TRIM_VALUE <= FIA_REF_TRIM_ENABLE_FLAG ? FIA_REF_TRIM_VALUE : `REF_TRIM_RST;
      CORE_REG_TRIM_VALUE <= FIA_CORE_REG_TRIM_ENABLE_FLAG ?
        FIA_CORE_REG_TRIM_VALUE : `CORE_TRIM_RST;
      IO_REG_TRIM_VALUE <= FIA_IO_REG_TRIM_ENABLE_FLAG ?
        FIA_IO_REG_TRIM_VALUE : `IO_TRIM_RST;
      REF_POWER_DOWN <= `CTRL_BIT_RST;
      IO_REG_POWER_DOWN <= `CTRL_BIT_RST;
      IO_REG_BYPASS <= `CTRL_BIT_RST;
      ref_flag_reg <= FIA_REF_TRIM_ENABLE_FLAG;
      core_flag_reg <= FIA_CORE_REG_TRIM_ENABLE_FLAG;
      io_flag_reg <= FIA_IO_REG_TRIM_ENABLE_FLAG;
    end
    else
    begin
      // the unlock state before this write decides; a locked write leaves fields alone
      if (wr_ref & unlocked[0])
      begin
        REF_TRIM_VALUE <= HWDATA[`REF_VAL_HI:0];
        REF_POWER_DOWN <= HWDATA[`REF_PD_BIT];
      end
      if (wr_core & unlocked[1])
      begin
        CORE_REG_TRIM_VALUE <= HWDATA[`CORE_VAL_HI:0];
      end
      if (wr_io & unlocked[2])
      begin
        IO_REG_TRIM_VALUE <= HWDATA[`IO_VAL_HI:`IO_VAL_LO];
        IO_REG_POWER_DOWN <= HWDATA[`IO_PD_BIT];
        IO_REG_BYPASS <= HWDATA[`IO_BYP_BIT];
      end
    end
  end

  // ----------------------------------------
  // protection status
  // ----------------------------------------
  // a lower page above the upper one gives size zero rather than a wrapped value
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      PROTECT_ENABLE_STATUS <= FIA_PROTECT_ENABLE_MATCH;
      PROTECT_OVERRIDE_STATUS <= ~FIA_PROTECT_OVERRIDE_MATCH;
      PROTECT_LOCAL_READ_STATUS <= FIA_PROTECT_LOCAL_READ_MATCH;
      PROTECT_UPPER_PAGE <= FIA_PROTECT_UPPER_PAGE;
      PROTECT_LOWER_PAGE <= FIA_PROTECT_LOWER_PAGE;
      if (FIA_PROTECT_UPPER_PAGE > FIA_PROTECT_LOWER_PAGE)
      begin
        PROTECT_SIZE_BYTES <= {FIA_PROTECT_UPPER_PAGE - FIA_PROTECT_LOWER_PAGE, 9'h000};
      end
      else
      begin
        PROTECT_SIZE_BYTES <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped indices read zero; writes there are dropped with an okay response
  always @*
  begin
    rd_word = 32'h0000_0000;
    case (idx_reg)
      `REF_TRIM_IDX:
      begin
        rd_word[`REF_UNLOCK_HI:`REF_UNLOCK_LO] = unlock_field[1:0];
        rd_word[`REF_PD_BIT] = REF_POWER_DOWN;
        rd_word[`REF_VAL_HI:0] = REF_TRIM_VALUE;
      end
      `CORE_TRIM_IDX:
      begin
        rd_word[`CORE_UNLOCK_HI:`CORE_UNLOCK_LO] = unlock_field[3:2];
        rd_word[`CORE_VAL_HI:0] = CORE_REG_TRIM_VALUE;
      end
      `IO_TRIM_IDX:
      begin
        rd_word[`IO_UNLOCK_HI:`IO_UNLOCK_LO] = unlock_field[5:4];
        rd_word[`IO_PD_BIT] = IO_REG_POWER_DOWN;
        rd_word[`IO_BYP_BIT] = IO_REG_BYPASS;
        rd_word[`IO_VAL_HI:`IO_VAL_LO] = IO_REG_TRIM_VALUE;
      end
      `PROTECT_IDX:
      begin
        rd_word[`PROT_EN_BIT] = PROTECT_ENABLE_STATUS;
        rd_word[`PROT_OV_BIT] = PROTECT_OVERRIDE_STATUS;
        rd_word[`PROT_LR_BIT] = PROTECT_LOCAL_READ_STATUS;
        rd_word[`PROT_UP_HI:`PROT_UP_LO] = PROTECT_UPPER_PAGE;
        rd_word[`PROT_LO_HI:0] = PROTECT_LOWER_PAGE;
      end
      `TRIM_FLAGS_IDX:
      begin
        rd_word[2:0] = {io_flag_reg, core_flag_reg, ref_flag_reg};
      end
      default:
      begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

endmodule // trim_config_regs

// *** inc/trim_map.vh ***
// trim_map.vh: register indices, field positions and reset values of the trim bank
// assumes byte address = 4 * index, one register per aligned 32-bit word
`ifndef TRIM_MAP_VH
`define TRIM_MAP_VH

// ----------------------------------------
// register indices (haddr[9:2])
// ----------------------------------------
`define REF_TRIM_IDX 8'h36
`define CORE_TRIM_IDX 8'h37
`define PROTECT_IDX 8'h38
`define IO_TRIM_IDX 8'h3e
`define TRIM_FLAGS_IDX 8'h3f

// ----------------------------------------
// field positions
// ----------------------------------------
`define REF_UNLOCK_HI 7
`define REF_UNLOCK_LO 6
`define REF_PD_BIT 5
`define REF_VAL_HI 4
`define CORE_UNLOCK_HI 7
`define CORE_UNLOCK_LO 6
`define CORE_VAL_HI 5
`define IO_UNLOCK_HI 31
`define IO_UNLOCK_LO 30
`define IO_PD_BIT 23
`define IO_BYP_BIT 22
`define IO_VAL_HI 17
`define IO_VAL_LO 16
`define PROT_EN_BIT 31
`define PROT_OV_BIT 30
`define PROT_LR_BIT 29
`define PROT_UP_HI 14
`define PROT_UP_LO 8
`define PROT_LO_HI 6
`define PAGE_SHIFT 9

// ----------------------------------------
// unlock codes and reset values
// ----------------------------------------
`define UNLOCK_CLEAR 2'b00
`define UNLOCK_STEP1 2'b01
`define UNLOCK_STEP2 2'b10
`define UNLOCK_OPEN 2'b11
`define REF_TRIM_RST 5'h00
`define CORE_TRIM_RST 6'h00
`define IO_TRIM_RST 2'b00
`define CTRL_BIT_RST 1'b0

`endif

// *** rtl/unlock_seq.v ***
// unlock_seq.v: two-bit write-unlock sequencer guarding one trim register
// assumes wr_en is a one-cycle pulse from the bus slave on the same clock
`include "trim_map.vh"

module unlock_seq
(
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [1:0] wr_val,
  output reg [1:0] field,
  output wire unlocked
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE = 4'b0001;
  localparam S_ONE = 4'b0010;
  localparam S_TWO = 4'b0100;
  localparam S_OPEN = 4'b1000;

  reg [3:0] state_reg;
  reg [3:0] state_next;

  assign unlocked = state_reg[3];

  always @*
  begin
    state_next = state_reg;
    if (wr_en)
    begin
      case (state_reg)
        S_IDLE: state_next = (wr_val == `UNLOCK_STEP1) ? S_ONE : S_IDLE;
        S_ONE: state_next = (wr_val == `UNLOCK_STEP2) ? S_TWO :
          ((wr_val == `UNLOCK_STEP1) ? S_ONE : S_IDLE);
        S_TWO: state_next = (wr_val == `UNLOCK_OPEN) ? S_OPEN :
          ((wr_val == `UNLOCK_STEP1) ? S_ONE : S_IDLE);
        S_OPEN: state_next = (wr_val == `UNLOCK_CLEAR) ? S_IDLE : S_OPEN;
        default: state_next = S_IDLE;
      endcase
    end
  end

  // the field reads back the step of the current state, so a wrong write before 11 drops it to 01 or 00
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      field <= `UNLOCK_CLEAR;
    end
    else
    begin
      state_reg <= state_next;
      case (state_next)
        S_ONE: field <= `UNLOCK_STEP1;
        S_TWO: field <= `UNLOCK_STEP2;
        S_OPEN: field <= `UNLOCK_OPEN;
        default: field <= `UNLOCK_CLEAR;
      endcase
    end
  end

endmodule // unlock_seq

// *** bench/trim_config_regs_checker.sv ***
// trim_config_regs_checker.sv: port assertions for the trim and protection bank
// assumes one clock domain and a synchronous active-high reset
`include "trim_map.vh"
module trim_config_regs_checker
(
  input wire CLK_SYS,
  input wire RESET,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire FIA_REF_TRIM_ENABLE_FLAG,
  input wire [4:0] FIA_REF_TRIM_VALUE,
  input wire FIA_CORE_REG_TRIM_ENABLE_FLAG,
  input wire [5:0] FIA_CORE_REG_TRIM_VALUE,
  input wire FIA_IO_REG_TRIM_ENABLE_FLAG,
  input wire [1:0] FIA_IO_REG_TRIM_VALUE,
  input wire FIA_PROTECT_ENABLE_MATCH,
  input wire FIA_PROTECT_OVERRIDE_MATCH,
  input wire FIA_PROTECT_LOCAL_READ_MATCH,
  input wire REF_POWER_DOWN,
  input wire [4:0] REF_TRIM_VALUE,
  input wire [5:0] CORE_REG_TRIM_VALUE,
  input wire [1:0] IO_REG_TRIM_VALUE,
  input wire PROTECT_ENABLE_STATUS,
  input wire PROTECT_OVERRIDE_STATUS,
  input wire PROTECT_LOCAL_READ_STATUS,
  input wire [6:0] PROTECT_UPPER_PAGE,
  input wire [6:0] PROTECT_LOWER_PAGE,
  input wire [15:0] PROTECT_SIZE_BYTES
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // ----------------------------------------
  // write data-phase tracker
  // ----------------------------------------
  reg wr_ph;
  reg [7:0] wr_idx;
  always @(posedge CLK_SYS)
  begin
    wr_ph <= HSEL & HTRANS[1] & HREADY & HWRITE & ~RESET;
    wr_idx <= HADDR[9:2];
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_REF_LOAD: assert property ($fell(RESET) |->
    REF_TRIM_VALUE == (FIA_REF_TRIM_ENABLE_FLAG ? FIA_REF_TRIM_VALUE : 5'h00)) else $error("ref trim load wrong");
  AST_CORE_LOAD: assert property ($fell(RESET) |->
    CORE_REG_TRIM_VALUE == (FIA_CORE_REG_TRIM_ENABLE_FLAG ? FIA_CORE_REG_TRIM_VALUE : 6'h00))
    else $error("core trim load wrong");
  AST_IO_LOAD: assert property ($fell(RESET) |->
    IO_REG_TRIM_VALUE == (FIA_IO_REG_TRIM_ENABLE_FLAG ? FIA_IO_REG_TRIM_VALUE : 2'b00)) else $error("io trim load wrong");
  AST_CORE_GUARD: assert property ($changed(CORE_REG_TRIM_VALUE) |->
    $past(wr_ph) && $past(wr_idx) == `CORE_TRIM_IDX) else $error("core trim changed without write");
  AST_REF_PD_GUARD: assert property ($changed(REF_POWER_DOWN) |->
    $past(wr_ph) && $past(wr_idx) == `REF_TRIM_IDX) else $error("ref power down changed without write");
  AST_PROT_EN: assert property (PROTECT_ENABLE_STATUS == FIA_PROTECT_ENABLE_MATCH)
    else $error("protect enable wrong");
  AST_PROT_OV: assert property (PROTECT_OVERRIDE_STATUS != FIA_PROTECT_OVERRIDE_MATCH)
    else $error("protect override wrong");
  AST_PROT_LR: assert property (!RESET ##1 !RESET |->
    $stable(PROTECT_LOCAL_READ_STATUS) && PROTECT_LOCAL_READ_STATUS == FIA_PROTECT_LOCAL_READ_MATCH)
    else $error("protect local read wrong");
  AST_PROT_SIZE: assert property (PROTECT_SIZE_BYTES == ((PROTECT_UPPER_PAGE > PROTECT_LOWER_PAGE) ?
    {PROTECT_UPPER_PAGE - PROTECT_LOWER_PAGE, 9'h000} : 16'h0000)) else $error("protect size wrong");
endmodule // trim_config_regs_checker

bind trim_config_regs trim_config_regs_checker i_trim_config_regs_checker (.*);

// *** bench/tb_top.sv ***
// tb_top.sv: register-level test of the trim and protection bank
// assumes the bank is the only AHB-Lite slave, its hreadyout being the bus hready
`include "trim_map.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_SYS, RESET, HSEL, HWRITE, ref_f, core_f, io_f, en_m, ov_m, lr_m;
  logic [1:0] HTRANS, io_v;
  logic [31:0] HADDR, HWDATA, q;
  logic [4:0] ref_v;
  logic [5:0] core_v;
  logic [6:0] up_p, lo_p;
  wire hready, hresp, ref_pd, io_pd, io_byp, pe, po, pl;
  wire [31:0] hrdata;
  wire [4:0] ref_t;
  wire [5:0] core_t;
  wire [1:0] io_t;
  wire [6:0] pu, plo;
  wire [15:0] psz;
  int n_mismatch = 0;
  int cmp_count = 0;
  trim_config_regs i_trim_config_regs (.CLK_SYS(CLK_SYS), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(hready), .HREADYOUT(hready),
    .HRESP(hresp), .HRDATA(hrdata), .FIA_REF_TRIM_ENABLE_FLAG(ref_f), .FIA_REF_TRIM_VALUE(ref_v),
    .FIA_CORE_REG_TRIM_ENABLE_FLAG(core_f), .FIA_CORE_REG_TRIM_VALUE(core_v), .FIA_IO_REG_TRIM_ENABLE_FLAG(io_f),
    .FIA_IO_REG_TRIM_VALUE(io_v), .FIA_PROTECT_ENABLE_MATCH(en_m), .FIA_PROTECT_OVERRIDE_MATCH(ov_m),
    .FIA_PROTECT_LOCAL_READ_MATCH(lr_m), .FIA_PROTECT_UPPER_PAGE(up_p), .FIA_PROTECT_LOWER_PAGE(lo_p),
    .REF_POWER_DOWN(ref_pd), .REF_TRIM_VALUE(ref_t), .CORE_REG_TRIM_VALUE(core_t), .IO_REG_TRIM_VALUE(io_t),
    .IO_REG_POWER_DOWN(io_pd), .IO_REG_BYPASS(io_byp), .PROTECT_ENABLE_STATUS(pe), .PROTECT_OVERRIDE_STATUS(po),
    .PROTECT_LOCAL_READ_STATUS(pl), .PROTECT_UPPER_PAGE(pu), .PROTECT_LOWER_PAGE(plo), .PROTECT_SIZE_BYTES(psz));
  // ----------------------------------------
  // bus and run-control tasks
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {22'h0, i, 2'b00};
    do @(posedge CLK_SYS); while (hready !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK_SYS); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    `CHK($sformatf("reg %h", i), e, q)
  endtask
  // walks the unlock field 01, 10, 11 at bit position s
  task automatic unl(input logic [7:0] i, input int s);
    for (int k = 1; k < 4; k++)
      xfer(1'b1, i, k << s);
  endtask
  task automatic rst();
    RESET <= 1'b1;
    repeat (16) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  initial
  begin
    #60000;
    n_mismatch++;
    stop_test;
  end
  initial
  begin
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA} <= 68'h0;
    {ref_f, core_f, io_f, en_m, ov_m, lr_m} <= 6'b101110;
    {ref_v, core_v, io_v, up_p, lo_p} <= {5'h15, 6'h2a, 2'b10, 7'h40, 7'h10};
    rst();
    rc(`REF_TRIM_IDX, 32'h15);
    rc(`CORE_TRIM_IDX, 32'h0);
    rc(`IO_TRIM_IDX, 32'h0002_0000);
    rc(`PROTECT_IDX, 32'h8000_4010);
    rc(`TRIM_FLAGS_IDX, 32'h5);
    `CHK("ref trim", 5'h15, ref_t)
    `CHK("core trim", 6'h00, core_t)
    `CHK("io trim", 2'b10, io_t)
    `CHK("protect enable", 1'b1, pe)
    `CHK("protect override", 1'b0, po)
    `CHK("local read", 1'b0, pl)
    `CHK("upper page", 7'h40, pu)
    `CHK("lower page", 7'h10, plo)
    `CHK("size", 16'h6000, psz)
    xfer(1'b1, `CORE_TRIM_IDX, 32'h3f);
    rc(`CORE_TRIM_IDX, 32'h0);
    xfer(1'b1, `CORE_TRIM_IDX, 32'h40);
    xfer(1'b1, `CORE_TRIM_IDX, 32'hc0);
    rc(`CORE_TRIM_IDX, 32'h0);
    unl(`CORE_TRIM_IDX, 6);
    rc(`CORE_TRIM_IDX, 32'hc0);
    xfer(1'b1, `CORE_TRIM_IDX, 32'hd5);
    rc(`CORE_TRIM_IDX, 32'hd5);
    `CHK("core trim", 6'h15, core_t)
    xfer(1'b1, `CORE_TRIM_IDX, 32'h6a);
    rc(`CORE_TRIM_IDX, 32'hea);
    xfer(1'b1, `CORE_TRIM_IDX, 32'h0);
    xfer(1'b1, `CORE_TRIM_IDX, 32'h3f);
    rc(`CORE_TRIM_IDX, 32'h0);
    unl(`IO_TRIM_IDX, 30);
    xfer(1'b1, `IO_TRIM_IDX, 32'hc0c1_0000);
    rc(`IO_TRIM_IDX, 32'hc0c1_0000);
    `CHK("io trim", 2'b01, io_t)
    `CHK("io power down", 1'b1, io_pd)
    `CHK("io bypass", 1'b1, io_byp)
    unl(`REF_TRIM_IDX, 6);
    xfer(1'b1, `REF_TRIM_IDX, 32'hea);
    rc(`REF_TRIM_IDX, 32'hea);
    `CHK("ref power down", 1'b1, ref_pd)
    `CHK("ref trim", 5'h0a, ref_t)
    xfer(1'b1, `REF_TRIM_IDX, 32'hc0);
    rc(`REF_TRIM_IDX, 32'hc0);
    `CHK("ref power down", 1'b0, ref_pd)
    xfer(1'b1, 8'h10, 32'hffff_ffff);
    rc(8'h10, 32'h0);
    `CHK("resp", 1'b0, hresp)
    xfer(1'b1, `PROTECT_IDX, 32'h0);
    rc(`PROTECT_IDX, 32'h8000_4010);
    // second reset in mid-run, flags clear, enable and override locations erased, local read matched
    {ref_f, core_f, io_f, en_m, ov_m, lr_m} <= 6'b000001;
    {up_p, lo_p} <= {7'h05, 7'h09};
    rst();
    rc(`REF_TRIM_IDX, 32'h0);
    rc(`IO_TRIM_IDX, 32'h0);
    rc(`TRIM_FLAGS_IDX, 32'h0);
    rc(`PROTECT_IDX, 32'h6000_0509);
    `CHK("core trim", 6'h00, core_t)
    `CHK("protect enable", 1'b0, pe)
    `CHK("protect override", 1'b1, po)
    `CHK("local read", 1'b1, pl)
    `CHK("size", 16'h0000, psz)
    stop_test;
  end
endmodule // tb_top
